// *** cpu_arch_regfile.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "regfile_consts.svh"
module cpu_arch_regfile
  import cpu_regfile_pkg::*;
#(
  parameter bit WIDE_ACC = 1'b1 // 1: 64-bit MAC, 0: 42-bit MAC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Operand read and result write
  input  wire rd_req_s     rd_i,
  input  wire wr_req_s     wr_i,
  output logic [31:0]      rd_a_o,
  output logic [31:0]      rd_b_o,
  // Control and system register writes
  input  wire logic        ctrl_we_i,
  input  wire ctrl_sel_e   ctrl_sel_i,
  input  wire logic [31:0] ctrl_data_i,
  input  wire logic        t_we_i,
  input  wire logic        t_i,
  // Program flow
  input  wire logic        pc_step_i,
  input  wire logic        pc_load_i,
  input  wire logic [31:0] pc_data_i,
  input  wire logic        call_i,
  input  wire logic [31:0] ret_addr_i,
  input  wire logic        ret_i,
  // Exception stack and vector fetch
  input  wire logic        exc_push_i,
  input  wire logic        exc_pop_i,
  input  wire logic        vec_fetch_i,
  input  wire logic [7:0]  vec_num_i,
  output logic             vec_req_o,
  output logic [31:0]      vec_addr_o,
  input  wire logic        vec_ack_i,
  input  wire logic [31:0] vec_data_i,
  // Address generation
  input  wire agen_mode_e  agen_mode_i,
  input  wire logic [3:0]  agen_reg_i,
  input  wire logic [31:0] agen_disp_i,
  output logic [31:0]      ea_o,
  // Multiplier
  input  wire mul_req_s    mul_i,
  output logic             mul_busy_o,
  output logic             mul_done_o,
  // Register views
  output logic             ready_o,
  output logic [31:0]      index_o,
  output logic [31:0]      stack_o,
  output logic [31:0]      status_o,
  output logic [31:0]      gbr_o,
  output logic [31:0]      vbr_o,
  output logic [31:0]      mac_high_reg_o,
  output logic [31:0]      mac_low_reg_o,
  output logic [31:0]      pr_o,
  output logic [31:0]      pc_o
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Clamp a 43-bit sum into the 42-bit accumulator range
  function automatic logic [41:0] sat42(input logic [42:0] s,
                                        input logic en);
    if (en && (s[42] != s[41])) begin
      sat42 = s[42] ? {1'b1, 41'h0} : {1'b0, {41{1'b1}}};
    end else begin
      sat42 = s[41:0];
    end
  endfunction : sat42

  state_s st_reg;  // Registered state
  state_s st_next; // Next state

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic signed [31:0] p16;
    logic signed [63:0] p32;
    logic [42:0]        s43;
    logic [63:0]        acc;
    logic [3:0]         wa;
    logic               run;
    p16 = $signed(mul_i.a[15:0]) * $signed(mul_i.b[15:0]);
    p32 = $signed(mul_i.a) * $signed(mul_i.b);
    s43 = 43'h0;
    acc = {st_reg.mac_high_reg, st_reg.mac_low_reg};
    wa  = wr_i.to_r0 ? `IDX_REG : wr_i.addr; // [RULE3]
    run = (st_reg.seq == RUN);
    st_next = st_reg;
    st_next.mdone = 1'b0;

    // Result write, only once the core is running
    if (run && wr_i.we) begin
      st_next.gpr[wa] = wr_i.data; // [RULE1] [RULE22]
    end

    // Exception frame moves the stack pointer by a whole frame
    if (run && exc_push_i) begin
      st_next.gpr[`SP_REG] = st_reg.gpr[`SP_REG] - `STACK_FRAME; // [RULE5]
    end else if (run && exc_pop_i) begin
      st_next.gpr[`SP_REG] = st_reg.gpr[`SP_REG] + `STACK_FRAME; // [RULE5]
    end

    // Control and system registers
    if (run && ctrl_we_i) begin
      unique case (ctrl_sel_i)
        SEL_SR:   st_next.sr = ctrl_data_i & `SR_WMASK; // [RULE7]
        SEL_GBR:  st_next.global_base_reg  = ctrl_data_i;            // [RULE6]
        SEL_VBR:  st_next.vector_base_reg  = ctrl_data_i;            // [RULE6]
        SEL_MAC_HIGH_REG: st_next.mac_high_reg = ctrl_data_i;            // [RULE10]
        SEL_MAC_LOW_REG: st_next.mac_low_reg = ctrl_data_i;            // [RULE10]
        SEL_PR:   st_next.pr   = ctrl_data_i;            // [RULE10]
        default:  st_next.sr   = st_reg.sr; // Illegal code: no effect
      endcase
    end
    // Condition bit update from compare results
    if (run && t_we_i) begin
      st_next.sr[`SR_T_BIT] = t_i; // [RULE7]
    end

    // Program counter: load beats return beats step
    if (run && pc_load_i) begin
      st_next.pc = pc_data_i; // [RULE13]
    end else if (run && ret_i) begin
      st_next.pc = st_reg.pr; // [RULE12]
    end else if (run && pc_step_i) begin
      st_next.pc = st_reg.pc + `PC_STEP; // [RULE14]
    end
    if (run && call_i) begin
      st_next.pr = ret_addr_i; // [RULE12]
    end

    // Multiplier: pending result commits after its latency
    if (st_reg.mcnt != 2'h0) begin
      st_next.mcnt = st_reg.mcnt - 2'h1;
      if (st_reg.mcnt == 2'h1) begin
        st_next.mac_low_reg  = st_reg.mres[31:0]; // [RULE11]
        if (st_reg.mhi) begin
          st_next.mac_high_reg = st_reg.mres[63:32];
        end
        st_next.mdone = 1'b1;
      end
    end else if (run && mul_i.start) begin
      unique case (mul_i.op)
        MUL16: begin
          // Only the low half is written
          st_next.mac_low_reg  = p16; // [RULE15]
          st_next.mdone = 1'b1;
        end
        MAC16: begin
          if (WIDE_ACC) begin
            st_next.mres = acc + {{32{p16[31]}}, p16}; // [RULE17]
          end else begin
            // One guard bit above the 42-bit accumulator
            s43 = {st_reg.mac_high_reg[9], st_reg.mac_high_reg[9:0], st_reg.mac_low_reg}
                + {{11{p16[31]}}, p16};
            st_next.mres[41:0] = sat42(s43, st_reg.sr[`SR_S_BIT]);
            st_next.mres[63:42] = {22{st_next.mres[41]}}; // [RULE16]
          end
          st_next.mhi  = 1'b1;
          st_next.mcnt = `MAC16_CYC - 2'h1;
        end
        MUL32: begin
          if (WIDE_ACC) begin
            st_next.mres = p32; // [RULE18]
            st_next.mhi  = 1'b1;
            st_next.mcnt = `MUL32_CYC - 2'h1;
          end
        end
        MAC32: begin
          if (WIDE_ACC) begin
            st_next.mres = acc + p32; // [RULE18]
            st_next.mhi  = 1'b1;
            st_next.mcnt = `MUL32_CYC - 2'h1;
          end
        end
      endcase
    end

    // Boot and exception vector sequencer
    unique case (st_reg.seq)
      BOOT_PC: begin
        if (vec_ack_i) begin
          st_next.pc    = vec_data_i; // [RULE21]
          st_next.vaddr = `VEC_SP_ADDR;
          st_next.seq   = BOOT_SP;
        end
      end
      BOOT_SP: begin
        if (vec_ack_i) begin
          st_next.gpr[`SP_REG] = vec_data_i; // [RULE20]
          st_next.vreq = 1'b0;
          st_next.rdy  = 1'b1;
          st_next.seq  = RUN;
        end
      end
      RUN: begin
        if (vec_fetch_i) begin
          // Vector table entries are one word each
          st_next.vaddr = st_reg.vector_base_reg + {22'h0, vec_num_i, 2'b00}; // [RULE9]
          st_next.vreq  = 1'b1;
          st_next.rdy   = 1'b0;
          st_next.seq   = VEC_WAIT;
        end
      end
      VEC_WAIT: begin
        if (vec_ack_i) begin
          st_next.pc   = vec_data_i; // [RULE9]
          st_next.vreq = 1'b0;
          st_next.rdy  = 1'b1;
          st_next.seq  = RUN;
        end
      end
    endcase

    // Read ports see this cycle's writes (write-first)
    st_next.rd_a = rd_i.a_from_r0 ? st_next.gpr[`IDX_REG]
                                  : st_next.gpr[rd_i.addr_a]; // [RULE22]
    st_next.rd_b = st_next.gpr[rd_i.addr_b];                  // [RULE22]

    // Effective address from a base plus index or displacement, or the stack pointer alone
    unique case (agen_mode_i)
      AG_IDX_REG:  st_next.ea = st_reg.gpr[agen_reg_i]
                              + st_reg.gpr[`IDX_REG];  // [RULE2]
      AG_GBR_DISP: st_next.ea = st_reg.global_base_reg + agen_disp_i; // [RULE8]
      AG_GBR_IDX:  st_next.ea = st_reg.global_base_reg
                              + st_reg.gpr[`IDX_REG];  // [RULE2] [RULE8]
      AG_STACK:    st_next.ea = st_reg.gpr[`SP_REG];    // [RULE4]
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Only mask bits, vbr and the boot fetch need a real reset;
  // everything else is cleared simply to keep simulation clean
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg       <= '0;                   // [RULE23]
      st_reg.seq   <= BOOT_PC;
      st_reg.sr    <= `SR_RESET;            // [RULE19]
      st_reg.vector_base_reg   <= `VBR_RESET;           // [RULE19]
      st_reg.vreq  <= 1'b1;
      st_reg.vaddr <= `VEC_PC_ADDR;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from the state register
  // ------------------------------------------------------------
  assign rd_a_o     = st_reg.rd_a;
  assign rd_b_o     = st_reg.rd_b;
  assign vec_req_o  = st_reg.vreq;
  assign vec_addr_o = st_reg.vaddr;
  assign ea_o       = st_reg.ea;
  assign mul_busy_o = (st_reg.mcnt != 2'h0);
  assign mul_done_o = st_reg.mdone;
  assign ready_o    = st_reg.rdy;
  assign index_o    = st_reg.gpr[`IDX_REG];
  assign stack_o    = st_reg.gpr[`SP_REG];
  assign status_o   = st_reg.sr;
  assign gbr_o      = st_reg.global_base_reg;
  assign vbr_o      = st_reg.vector_base_reg;
  assign mac_high_reg_o     = st_reg.mac_high_reg;
  assign mac_low_reg_o     = st_reg.mac_low_reg;
  assign pr_o       = st_reg.pr;
  assign pc_o       = st_reg.pc;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  wire run_w = (st_reg.seq == RUN);
  wire go16  = run_w && mul_i.start && !mul_busy_o
               && (mul_i.op == MAC16);

  sequence mac_go;
    go16;
  endsequence
  sequence mac_end;
    mul_busy_o && !mul_done_o ##1 mul_done_o && !mul_busy_o;
  endsequence

  boot_pc_load_a: assert property ( // [RULE21]
    st_reg.seq == BOOT_PC && vec_ack_i |=>
      pc_o == $past(vec_data_i) && st_reg.seq == BOOT_SP)
    else $error("pc not loaded from vector table");
  boot_sp_load_a: assert property ( // [RULE20]
    st_reg.seq == BOOT_SP && vec_ack_i |=>
      stack_o == $past(vec_data_i) && ready_o)
    else $error("stack pointer not loaded from vector table");
  boot_reset_a: assert property ( // [RULE19]
    st_reg.seq == BOOT_PC |->
      status_o[7:4] == 4'hf && vbr_o == 32'h0 && !ready_o)
    else $error("mask bits or vbr wrong during boot");
  read_bypass_a: assert property ( // [RULE22]
    run_w && wr_i.we && !wr_i.to_r0 && wr_i.addr != `SP_REG
      && rd_i.addr_b == wr_i.addr |=> rd_b_o == $past(wr_i.data))
    else $error("read port missed same-cycle write");
  mac_latency_a: assert property ( // [RULE16]
    mac_go |=> mac_end)
    else $error("mac result not committed after two cycles");
  mul16_result_a: assert property ( // [RULE15]
    run_w && mul_i.start && !mul_busy_o && mul_i.op == MUL16 |=>
      mul_done_o && mac_low_reg_o == $past(32'($signed(mul_i.a[15:0])
                                     * $signed(mul_i.b[15:0]))))
    else $error("16x16 product wrong in mac low");
  stack_push_a: assert property ( // [RULE5]
    run_w && exc_push_i |=> stack_o == $past(stack_o) - 32'h8)
    else $error("stack not lowered by one frame");
  call_save_a: assert property ( // [RULE12]
    run_w && call_i && !(ctrl_we_i && ctrl_sel_i == SEL_PR) |=>
      pr_o == $past(ret_addr_i))
    else $error("return address not saved");
  vector_addr_a: assert property ( // [RULE9]
    run_w && vec_fetch_i |=> vec_req_o
      && vec_addr_o == $past(vbr_o) + {22'h0, $past(vec_num_i), 2'b00})
    else $error("vector address not based on vbr");
  pc_step_a: assert property ( // [RULE14]
    run_w && pc_step_i && !pc_load_i && !ret_i && !vec_ack_i |=>
      pc_o == $past(pc_o) + 32'h2)
    else $error("pc did not advance one instruction");
  gbr_disp_a: assert property ( // [RULE8]
    agen_mode_i == AG_GBR_DISP |=>
      ea_o == $past(gbr_o) + $past(agen_disp_i))
    else $error("global base address wrong");

endmodule : cpu_arch_regfile
`default_nettype wire

// *** cpu_architectural_register_file_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module cpu_architectural_register_file_tb import cpu_regfile_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [31:0] PC_BOOT = 32'h00000400; // Boot PC word
  localparam logic [31:0] SP_BOOT = 32'h0000f000; // Boot SP word
  logic        clk_i = 1'b0, resetn_i = 1'b0;
  rd_req_s     rd_i;
  wr_req_s     wr_i;
  mul_req_s    mul_i;
  ctrl_sel_e   ctrl_sel_i;
  agen_mode_e  agen_mode_i;
  logic        ctrl_we_i, t_we_i, t_i, pc_step_i, pc_load_i, call_i, ret_i;
  logic        exc_push_i, exc_pop_i, vec_fetch_i, vec_ack_i, slow;
  logic        vec_req_o, mul_busy_o, mul_done_o, ready_o;
  logic [3:0]  agen_reg_i;
  logic [7:0]  vec_num_i;
  logic [31:0] ctrl_data_i, pc_data_i, ret_addr_i, vec_data_i, agen_disp_i;
  logic [31:0] rd_a_o, rd_b_o, vec_addr_o, ea_o, index_o, stack_o;
  logic [31:0] status_o, gbr_o, vbr_o, mac_high_reg_o, mac_low_reg_o, pr_o, pc_o, aexp [4];
  int          num_errors = 0, checked = 0;
  // Control writes: selector, data written, value read back
  typedef struct { ctrl_sel_e sel; logic [31:0] d, e; } row_s;
  row_s rows [7] = '{'{SEL_SR, 32'hffffffff, 32'h000003f3},
    '{SEL_SR, 32'h0, 32'h0}, '{SEL_GBR, 32'h12345678, 32'h12345678},
    '{SEL_MAC_HIGH_REG, 32'h0000abcd, 32'h0000abcd},
    '{SEL_MAC_LOW_REG, 32'h0000ffff, 32'h0000ffff},
    '{SEL_PR, 32'h00000800, 32'h00000800},
    '{SEL_VBR, 32'h00000100, 32'h00000100}};

  cpu_arch_regfile #(.WIDE_ACC(1'b1)) uut (.clk_i, .resetn_i, .rd_i, .wr_i,
    .rd_a_o, .rd_b_o, .ctrl_we_i, .ctrl_sel_i, .ctrl_data_i, .t_we_i, .t_i,
    .pc_step_i, .pc_load_i, .pc_data_i, .call_i, .ret_addr_i, .ret_i,
    .exc_push_i, .exc_pop_i, .vec_fetch_i, .vec_num_i, .vec_req_o,
    .vec_addr_o, .vec_ack_i, .vec_data_i, .agen_mode_i, .agen_reg_i,
    .agen_disp_i, .ea_o, .mul_i, .mul_busy_o, .mul_done_o, .ready_o,
    .index_o, .stack_o, .status_o, .gbr_o, .vbr_o, .mac_high_reg_o, .mac_low_reg_o, .pr_o,
    .pc_o);
  vec_mem_model #(.PC_BOOT(PC_BOOT), .SP_BOOT(SP_BOOT)) mem (.clk_i,
    .resetn_i, .req_i(vec_req_o), .addr_i(vec_addr_o), .slow_i(slow),
    .ack_o(vec_ack_i), .data_o(vec_data_i));

  // 250 MHz core clock
  always #2 clk_i = ~clk_i;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] gd(input int i);
    return (32'h01010101 * i) ^ 32'h5a000000; // Distinct word per register
  endfunction : gd
  function automatic logic [31:0] view(input ctrl_sel_e s);
    case (s)
      SEL_SR: return status_o;
      SEL_GBR: return gbr_o;
      SEL_VBR: return vbr_o;
      SEL_MAC_HIGH_REG: return mac_high_reg_o;
      SEL_MAC_LOW_REG: return mac_low_reg_o;
      default: return pr_o;
    endcase
  endfunction : view
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Drop all one-cycle strobes
  task automatic idle();
    wr_i.we <= 1'b0;
    ctrl_we_i <= 1'b0;
    t_we_i <= 1'b0;
    pc_step_i <= 1'b0;
    pc_load_i <= 1'b0;
    call_i <= 1'b0;
    ret_i <= 1'b0;
    exc_push_i <= 1'b0;
    exc_pop_i <= 1'b0;
    vec_fetch_i <= 1'b0;
    mul_i.start <= 1'b0;
  endtask : idle
  // Hold the request for n edges, release, then look mid-cycle
  task automatic run(input int n);
    repeat (n) @(posedge clk_i);
    idle();
    @(negedge clk_i);
  endtask : run
  // Bounded wait for the sequencer to reach the run state
  task automatic wait_rdy();
    int k;
    k = 0;
    while (ready_o !== 1'b1 && k < 100) begin
      @(negedge clk_i);
      k++;
    end
    chk("ready", ready_o, 1'b1);
  endtask : wait_rdy
  task automatic final_report();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #80000;
    num_errors++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rd_i, wr_i, mul_i, ctrl_data_i, pc_data_i, ret_addr_i} = '0;
    {ctrl_we_i, t_we_i, t_i, pc_step_i, pc_load_i, call_i, ret_i} = '0;
    {exc_push_i, exc_pop_i, vec_fetch_i, slow, vec_num_i} = '0;
    {agen_reg_i, agen_disp_i} = '0;
    ctrl_sel_i = SEL_SR;
    agen_mode_i = AG_IDX_REG;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_rdy();
    chk("pc", pc_o, PC_BOOT);
    chk("sp", stack_o, SP_BOOT);
    chk("sr", status_o, 32'h000000f0);
    chk("vbr", vbr_o, 32'h0);
    foreach (rows[k]) begin
      @(posedge clk_i);
      ctrl_we_i <= 1'b1;
      ctrl_sel_i <= rows[k].sel;
      ctrl_data_i <= rows[k].d;
      run(1);
      chk("ctrl", view(rows[k].sel), rows[k].e);
    end
    @(posedge clk_i);
    t_we_i <= 1'b1;
    t_i <= 1'b1;
    run(1);
    chk("tbit", status_o, 32'h1);
    // Write each register and read it back in the same cycle
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      wr_i <= '{1'b1, 1'b0, 4'(i), gd(i)};
      rd_i <= '{4'(i), 4'(i), 1'b0};
      run(1);
      chk("rdb_wf", rd_b_o, gd(i));
    end
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      rd_i <= '{4'(i), 4'(15 - i), 1'b0};
      run(1);
      chk("rda", rd_a_o, gd(i));
      chk("rdb", rd_b_o, gd(15 - i));
    end
    @(posedge clk_i);
    rd_i <= '{4'h7, 4'h7, 1'b1};
    run(1);
    chk("rda_r0", rd_a_o, gd(0));
    chk("index", index_o, gd(0));
    chk("stack", stack_o, gd(15));
    @(posedge clk_i);
    wr_i <= '{1'b1, 1'b1, 4'h5, 32'hcafe0000};
    rd_i <= '{4'h5, 4'h5, 1'b0};
    run(1);
    chk("to_r0", index_o, 32'hcafe0000);
    chk("r5_kept", rd_b_o, gd(5));
    aexp = '{gd(2) + 32'hcafe0000, 32'h12345678 + 32'h40,
             32'h12345678 + 32'hcafe0000, gd(15)};
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      agen_mode_i <= agen_mode_e'(m);
      agen_reg_i <= 4'h2;
      agen_disp_i <= 32'h40;
      run(1);
      chk("ea", ea_o, aexp[m]);
    end
    @(posedge clk_i);
    exc_push_i <= 1'b1;
    run(1);
    chk("push", stack_o, gd(15) - 32'h8);
    @(posedge clk_i);
    exc_pop_i <= 1'b1;
    run(1);
    chk("pop", stack_o, gd(15));
    @(posedge clk_i);
    call_i <= 1'b1;
    ret_addr_i <= 32'h00002000;
    run(1);
    chk("call", pr_o, 32'h00002000);
    @(posedge clk_i);
    ret_i <= 1'b1;
    run(1);
    chk("ret", pc_o, 32'h00002000);
    @(posedge clk_i);
    pc_step_i <= 1'b1;
    run(3);
    chk("step3", pc_o, 32'h00002006);
    @(posedge clk_i);
    pc_load_i <= 1'b1;
    pc_data_i <= 32'h00003000;
    run(1);
    chk("load", pc_o, 32'h00003000);
    // Vector fetch against a slow memory
    @(posedge clk_i);
    slow <= 1'b1;
    vec_fetch_i <= 1'b1;
    vec_num_i <= 8'h05;
    run(1);
    chk("vaddr", vec_addr_o, 32'h00000114);
    chk("vreq", vec_req_o, 1'b1);
    chk("busy_fetch", ready_o, 1'b0);
    wait_rdy();
    chk("vpc", pc_o, 32'h00001114);
    @(posedge clk_i);
    mul_i <= '{1'b1, MUL16, 32'hfffffffd, 32'h00000007};
    run(1);
    chk("m16_done", mul_done_o, 1'b1);
    chk("m16_lo", mac_low_reg_o, 32'hffffffeb);
    chk("m16_hi", mac_high_reg_o, 32'h0000abcd);
    @(posedge clk_i);
    mul_i <= '{1'b1, MUL32, 32'h00010000, 32'h00010000};
    run(1);
    chk("m32_busy", mul_busy_o, 1'b1);
    @(negedge clk_i);
    chk("m32_done", mul_done_o, 1'b1);
    chk("m32", {mac_high_reg_o, mac_low_reg_o}, 64'h0000000100000000);
    // Start held into the busy cycle must be taken once only
    @(posedge clk_i);
    mul_i <= '{1'b1, MAC16, 32'h00000002, 32'h00000003};
    run(2);
    chk("mac_done", mul_done_o, 1'b1);
    chk("mac", {mac_high_reg_o, mac_low_reg_o}, 64'h0000000100000006);
    @(negedge clk_i);
    chk("mac_once", mul_done_o, 1'b0);
    // 32x32 accumulate adds onto the pair left by the last MAC
    @(posedge clk_i);
    mul_i <= '{1'b1, MAC32, 32'h00000002, 32'h00000003};
    run(2);
    chk("mac32", {mac_high_reg_o, mac_low_reg_o}, 64'h000000010000000c);
    // Second reset in mid-run
    @(posedge clk_i);
    resetn_i <= 1'b0;
    slow <= 1'b0;
    @(negedge clk_i);
    chk("rst_sr", status_o, 32'h000000f0);
    chk("rst_vbr", vbr_o, 32'h0);
    chk("rst_rdy", ready_o, 1'b0);
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_rdy();
    chk("pc2", pc_o, PC_BOOT);
    chk("sp2", stack_o, SP_BOOT);
    final_report();
  end
endmodule : cpu_architectural_register_file_tb
`default_nettype wire

// *** cpu_regfile_pkg.sv ***
package cpu_regfile_pkg;
  // Multiplier operations
  typedef enum logic [1:0] {
    MUL16 = 2'h0, MAC16 = 2'h1, MUL32 = 2'h2, MAC32 = 2'h3
  } mul_op_e;
  // Control/system register selector
  typedef enum logic [2:0] {
    SEL_SR = 3'h0, SEL_GBR = 3'h1, SEL_VBR = 3'h2,
    SEL_MAC_HIGH_REG = 3'h3, SEL_MAC_LOW_REG = 3'h4, SEL_PR = 3'h5
  } ctrl_sel_e;
  // Address generator modes
  typedef enum logic [1:0] {
    AG_IDX_REG = 2'h0, AG_GBR_DISP = 2'h1,
    AG_GBR_IDX = 2'h2, AG_STACK = 2'h3
  } agen_mode_e;
  // Sequencer, Gray along boot path
  typedef enum logic [1:0] {
    BOOT_PC = 2'b00, BOOT_SP = 2'b01, RUN = 2'b11, VEC_WAIT = 2'b10
  } seq_e;
  // Read port request
  typedef struct packed {
    logic [3:0] addr_a;
    logic [3:0] addr_b;
    logic       a_from_r0;
  } rd_req_s;
  // Write port request
  typedef struct packed {
    logic        we;
    logic        to_r0;
    logic [3:0]  addr;
    logic [31:0] data;
  } wr_req_s;
  // Multiplier request
  typedef struct packed {
    logic        start;
    mul_op_e     op;
    logic [31:0] a;
    logic [31:0] b;
  } mul_req_s;
  // All state of the register file
  typedef struct packed {
    seq_e             seq;
    logic             rdy;
    logic [15:0][31:0] gpr;
    logic [31:0]      sr, global_base_reg, vector_base_reg, mac_high_reg, mac_low_reg, pr, pc;
    logic [31:0]      rd_a, rd_b, ea, vaddr;
    logic             vreq;
    logic [1:0]       mcnt;
    logic             mhi, mdone;
    logic [63:0]      mres;
  } state_s;
endpackage : cpu_regfile_pkg

// *** regfile_consts.svh ***
`ifndef REGFILE_CONSTS_SVH
`define REGFILE_CONSTS_SVH
// Notes on behaviour
// [RULE1] Sixteen 32-bit general registers, numbered 0-15
// [RULE2] Register zero indexes indexed addressing modes
// [RULE3] Register zero is an implicit fixed operand
// [RULE4] Register fifteen is the hardware stack pointer
// [RULE5] Exceptions push/pop status and PC via fifteen
// [RULE6] Three 32-bit control registers exist
// [RULE7] Status word holds condition and mask bits
// [RULE8] Global base forms global-base effective addresses
// [RULE9] Vector base is base of vector area
// [RULE10] Four 32-bit system registers exist
// [RULE11] Multiplier results land in MAC pair
// [RULE12] Call saves return address; return uses it
// [RULE13] Program counter tracks and steers program flow
// [RULE14] One basic instruction per clock sustained
// [RULE15] 16x16 multiply gives 32 bits, 1-3 cycles
// [RULE16] Narrow variant: 42-bit saturating accumulate
// [RULE17] Wide variant: 64-bit accumulate
// [RULE18] Wide variant: 32x32 gives 64 bits
// [RULE19] Reset: mask bits ones, reserved zero, vbr zero
// [RULE20] Reset loads stack register from vector table
// [RULE21] Reset loads program counter from vector table
// [RULE22] Two read ports, one write port per cycle
// [RULE23] Other registers need no reset value
`define SR_T_BIT     0
`define SR_S_BIT     1
`define SR_MASK_LO   4
`define SR_RESET     32'h000000f0
`define SR_WMASK     32'h000003f3
`define VBR_RESET    32'h00000000
`define VEC_PC_ADDR  32'h00000000
`define VEC_SP_ADDR  32'h00000004
`define STACK_FRAME  32'h00000008
`define PC_STEP      32'h00000002
`define IDX_REG      4'h0
`define SP_REG       4'hf
`define MUL16_CYC    2'h1
`define MAC16_CYC    2'h2
`define MUL32_CYC    2'h2
`endif

// *** vec_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Memory side of the vector fetch port, prompt or slow on demand
module vec_mem_model #(
  parameter logic [31:0] PC_BOOT = 32'h00000400, // Boot PC word
  parameter logic [31:0] SP_BOOT = 32'h0000f000  // Boot SP word
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Request from the core, and the slow-mode switch
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        slow_i,
  // Answer to the core
  output logic             ack_o,
  output logic [31:0]      data_o
);
  logic [1:0] wait_reg; // Cycles waited on this request

  // ----------------------------------------
  // Vector table contents
  // ----------------------------------------
  function automatic logic [31:0] word(input logic [31:0] a);
    if (a == 32'h0) return PC_BOOT;
    if (a == 32'h4) return SP_BOOT;
    return 32'h00001000 + a;
  endfunction : word

  // One ack per request; idle data toggles so stale words never match
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o    <= 1'b0;
      data_o   <= 32'h0;
      wait_reg <= 2'h0;
    end else if (req_i && !ack_o && (!slow_i || wait_reg == 2'h3)) begin
      ack_o    <= 1'b1;
      data_o   <= word(addr_i);
      wait_reg <= 2'h0;
    end else begin
      ack_o    <= 1'b0;
      data_o   <= ~data_o;
      wait_reg <= (req_i && !ack_o) ? wait_reg + 2'h1 : 2'h0;
    end
  end
endmodule : vec_mem_model
`default_nettype wire
